// ===== hw/omw_pkg.sv
// Package for the output module select and watchdog block.
// Assumes a 100 MHz system clock; all users reference names as omw_pkg::name.
package omw_pkg;
  // Clock rate
  localparam int unsigned CLOCK_HZ = 100_000_000;
  // Watchdog periods as printed, in milliseconds
  localparam int unsigned FIRST_PERIOD_MS = 20;
  localparam int unsigned SECOND_PERIOD_MS = 10;
  // Derived cycle counts
  localparam int unsigned FIRST_PERIOD_CYC = FIRST_PERIOD_MS * (CLOCK_HZ / 1000);
  localparam int unsigned SECOND_PERIOD_CYC = SECOND_PERIOD_MS * (CLOCK_HZ / 1000);
  // Bit address layout: A3 is MSB, A14 is LSB of a 12-bit hardware bit address
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SEL_MSB = 11; // A3
  localparam int unsigned SEL_LSB = 4; // A10
  localparam int unsigned FUNC_BIT = 3; // A11
  localparam int unsigned LOW_MSB = 2; // A12
  localparam int unsigned LOW_LSB = 0; // A14
  // Displacement of the restart function and of the second-timeout poll bit
  localparam logic [3:0] RESTART_DISP = 4'h8;
  localparam logic [2:0] POLL_INDEX = 3'h0;
  // Avalon register offsets (byte addresses)
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h0c;
  // Status / mask bit positions
  localparam int unsigned EV_FIRST = 0;
  localparam int unsigned EV_SECOND = 1;
  localparam int unsigned EV_RESTART = 2;
  localparam int unsigned EV_W = 3;
  // Config bit positions and reset value
  localparam int unsigned CFG_OUT_RESET = 0;
  localparam int unsigned CFG_IRQ_PF = 1;
  localparam int unsigned CFG_IRQ_NMI = 2;
  localparam int unsigned CFG_HOLD = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;
  // Watchdog state
  typedef enum logic [1:0] {
    OMW_FIRST = 2'b00,
    OMW_SECOND = 2'b01,
    OMW_DONE = 2'b10
  } omw_state_e;
  // Bit-serial bus access from the host
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic wdata;
  } omw_cru_s;
endpackage : omw_pkg

// ===== hw/omw_watchdog.sv
// Module select comparator, constant-data multiplexer and two-stage watchdog.
// Assumes bit-serial bus strobes are synchronous to i_clock, one cycle each.
// Operation
// [R01] Select only when A3..A10 equal base jumpers, A3 to position 8.
// [R02] Fitted base jumper reads zero, open reads one.
// [R03] Base switch ON reads zero, OFF reads one.
// [R04] Base addresses start at zero in steps of sixteen bit addresses.
// [R05] Read uses A12..A14 to pick one of eight constant-data bits.
// [R06] Constant-data bit fitted or ON reads zero, open or OFF one.
// [R07] Watchdog starts on bus I/O reset and on software restart.
// [R08] Default periods: first 20 ms, then second 10 ms.
// [R09] Write to displacement 8 restarts the countdown from the beginning.
// [R10] First timeout opens all outputs if output-reset option selected.
// [R11] First timeout asserts power-fail when that option is selected.
// [R12] First timeout asserts non-maskable interrupt instead when selected.
// [R13] With no interrupt option, first timeout signals nothing to host.
// [R14] Second timeout pulls grant-out low if hold option selected.
// [R15] Poll bit position 1 reads one before second timeout, zero after.
// [R16] Synchronous down-counter periods; second-timeout flag stays until restart.
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module omw_watchdog #(
  parameter int unsigned FIRST_CYC = omw_pkg::FIRST_PERIOD_CYC,
  parameter int unsigned SECOND_CYC = omw_pkg::SECOND_PERIOD_CYC
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Backplane side
  input wire logic i_bus_io_reset_n,
  input wire omw_pkg::omw_cru_s i_cru,
  output logic o_cru_rdata,
  output logic o_cru_selected,
  input wire logic [7:0] i_base_select_jumpers,
  input wire logic [7:0] i_constant_data_jumpers,
  output logic o_outputs_open,
  output logic o_power_fail_n,
  output logic o_nmi_n,
  output logic o_bus_grant_out_n,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq
);
  localparam int unsigned CNT_W = $clog2(FIRST_CYC > SECOND_CYC ? FIRST_CYC : SECOND_CYC) + 1;

  // Zero-length periods would make the two stages collapse into one edge
  if (FIRST_CYC < 1 || SECOND_CYC < 1) begin : g_bad_period
    $error("omw_watchdog: watchdog periods must be at least one cycle");
  end

  // Module select: jumpers already read fitted/ON as zero, open/OFF as one
  wire logic [7:0] sel_field;
  wire logic [7:0] base_value;
  wire logic selected;
  assign sel_field = i_cru.addr[omw_pkg::SEL_MSB:omw_pkg::SEL_LSB];
  assign base_value = i_base_select_jumpers; // see [R02] see [R03]
  // Bit 7 of both is A3 / position 8; low four address bits are local, see [R04]
  assign selected = (sel_field == base_value); // see [R01]
  assign o_cru_selected = selected;

  // Function decode
  wire logic func_aux;
  wire logic [2:0] low_index;
  wire logic restart_wr;
  assign func_aux = i_cru.addr[omw_pkg::FUNC_BIT];
  assign low_index = i_cru.addr[omw_pkg::LOW_MSB:omw_pkg::LOW_LSB];
  // A13/A14 ignored for aux outputs, so displacements 8..b all restart
  assign restart_wr = selected && i_cru.wr && func_aux &&
                      (low_index[2] == omw_pkg::RESTART_DISP[2]); // see [R09]

  // Watchdog state and counter
  omw_pkg::omw_state_e state_q, state_d;
  logic [CNT_W-1:0] count_q, count_d;
  logic second_seen_q;
  wire logic restart;
  wire logic count_end;
  wire logic first_hit;
  wire logic second_hit;
  assign restart = !i_bus_io_reset_n || restart_wr; // see [R07]
  assign count_end = (count_q == '0);
  assign first_hit = (state_q == omw_pkg::OMW_FIRST) && count_end && !restart;
  assign second_hit = (state_q == omw_pkg::OMW_SECOND) && count_end && !restart;

  // Next-state logic; restart always reloads the first period
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    if (restart) begin
      state_d = omw_pkg::OMW_FIRST;
      count_d = CNT_W'(FIRST_CYC - 1); // see [R08] see [R16]
    end else begin
      unique case (state_q)
        omw_pkg::OMW_FIRST: begin
          if (count_end) begin
            state_d = omw_pkg::OMW_SECOND;
            count_d = CNT_W'(SECOND_CYC - 1); // see [R08]
          end else begin
            count_d = count_q - 1'b1; // see [R16]
          end
        end
        omw_pkg::OMW_SECOND: begin
          if (count_end) begin
            state_d = omw_pkg::OMW_DONE;
          end else begin
            count_d = count_q - 1'b1;
          end
        end
        omw_pkg::OMW_DONE: begin
          state_d = omw_pkg::OMW_DONE;
        end
        default: begin
          state_d = omw_pkg::OMW_FIRST;
        end
      endcase
    end
  end

  // Counter starts at reset as if a bus reset had just occurred
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= omw_pkg::OMW_FIRST;
      count_q <= CNT_W'(FIRST_CYC - 1);
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // First-timeout latch and second-timeout latch, both held until restart
  logic first_seen_q;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      first_seen_q <= 1'b0;
      second_seen_q <= 1'b0;
    end else begin
      first_seen_q <= restart ? 1'b0 : (first_seen_q | first_hit);
      second_seen_q <= restart ? 1'b0 : (second_seen_q | second_hit); // see [R16]
    end
  end

  // Configuration register
  logic [3:0] cfg_q;
  wire logic opt_out_reset;
  wire logic opt_pf;
  wire logic opt_nmi;
  wire logic opt_hold;
  assign opt_out_reset = cfg_q[omw_pkg::CFG_OUT_RESET];
  assign opt_pf = cfg_q[omw_pkg::CFG_IRQ_PF];
  // Non-maskable takes the place of power-fail when both are chosen
  assign opt_nmi = cfg_q[omw_pkg::CFG_IRQ_NMI];
  assign opt_hold = cfg_q[omw_pkg::CFG_HOLD];

  // Timeout actions, registered so the pins are glitch free
  logic outputs_open_q;
  logic power_fail_n_q;
  logic nmi_n_q;
  logic grant_out_n_q;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      outputs_open_q <= 1'b0;
      power_fail_n_q <= 1'b1;
      nmi_n_q <= 1'b1;
      grant_out_n_q <= 1'b1;
    end else begin
      outputs_open_q <= (first_seen_q || first_hit) && !restart && opt_out_reset; // see [R10]
      power_fail_n_q <= !((first_seen_q || first_hit) && !restart && opt_pf && !opt_nmi); // see [R11] see [R13]
      nmi_n_q <= !((first_seen_q || first_hit) && !restart && opt_nmi); // see [R12] see [R13]
      grant_out_n_q <= !((second_seen_q || second_hit) && !restart && opt_hold); // see [R14]
    end
  end
  assign o_outputs_open = outputs_open_q;
  assign o_power_fail_n = power_fail_n_q;
  assign o_nmi_n = nmi_n_q;
  assign o_bus_grant_out_n = grant_out_n_q;

  // Constant-data read; position 1 is the poll bit when left open
  wire logic [7:0] const_bits;
  wire logic rd_bit;
  assign const_bits = {i_constant_data_jumpers[7:1],
                       i_constant_data_jumpers[0] & !second_seen_q}; // see [R15]
  assign rd_bit = const_bits[low_index]; // see [R05] see [R06]

  // Read data flip-flop; only aux reads of a selected module answer
  logic cru_rdata_q;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cru_rdata_q <= 1'b0;
    end else if (selected && i_cru.rd && func_aux) begin
      cru_rdata_q <= rd_bit;
    end
  end
  assign o_cru_rdata = cru_rdata_q;

  // Avalon slave: one wait cycle then answer, so every access takes two cycles
  logic ack_q;
  wire logic req;
  wire logic wr_take;
  wire logic [2:0] events;
  assign req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && !ack_q;
  assign wr_take = i_avs_write && ack_q;
  assign events = {restart_wr, second_hit, first_hit};

  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [31:0] rdata_q;
  wire logic [31:0] rdata_d;
  assign rdata_d = (i_avs_address == omw_pkg::REG_STATUS) ? {29'h0, status_q} :
                   (i_avs_address == omw_pkg::REG_MASK) ? {29'h0, mask_q} :
                   (i_avs_address == omw_pkg::REG_CONFIG) ? {28'h0, cfg_q} :
                   (i_avs_address == omw_pkg::REG_STATE) ?
                     {28'h0, second_seen_q, first_seen_q, state_q} : 32'h0;

  // Access handshake and read capture
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= req && !ack_q;
      rdata_q <= (i_avs_read && !ack_q) ? rdata_d : rdata_q;
    end
  end
  assign o_avs_readdata = rdata_q;

  // Sticky status: a new event wins over a write-one clear
  wire logic [2:0] clr;
  assign clr = (wr_take && i_avs_address == omw_pkg::REG_STATUS) ? i_avs_writedata[2:0] : 3'h0;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_q <= 3'h0;
      mask_q <= 3'h0;
      cfg_q <= omw_pkg::CFG_RESET;
    end else begin
      status_q <= (status_q & ~clr) | events;
      if (wr_take && i_avs_address == omw_pkg::REG_MASK) begin
        mask_q <= i_avs_writedata[2:0];
      end
      if (wr_take && i_avs_address == omw_pkg::REG_CONFIG) begin
        cfg_q <= i_avs_writedata[3:0];
      end
    end
  end
  assign o_irq = |(status_q & mask_q);

  // Checks
  select_match_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_cru_selected == (i_cru.addr[11:4] == i_base_select_jumpers)) // see [R01]
    else $error("select does not follow base compare");
  restart_reload_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    restart |=> (state_q == omw_pkg::OMW_FIRST && count_q == CNT_W'(FIRST_CYC - 1))) // see [R09]
    else $error("restart did not reload first period");
  bus_reset_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_bus_io_reset_n |=> state_q == omw_pkg::OMW_FIRST) // see [R07]
    else $error("bus reset did not start watchdog");
  first_to_second_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    first_hit |=> (state_q == omw_pkg::OMW_SECOND && count_q == CNT_W'(SECOND_CYC - 1))) // see [R08]
    else $error("second period not loaded");
  open_outputs_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (first_hit && opt_out_reset) |=> o_outputs_open) // see [R10]
    else $error("outputs not opened at first timeout");
  power_fail_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (first_hit && opt_pf && !opt_nmi) |=> !o_power_fail_n && o_nmi_n) // see [R11]
    else $error("power fail not raised");
  nmi_only_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (first_hit && opt_nmi) |=> !o_nmi_n && o_power_fail_n) // see [R12]
    else $error("nmi not raised alone");
  quiet_host_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!opt_pf && !opt_nmi && $stable(cfg_q)) |=> o_power_fail_n && o_nmi_n) // see [R13]
    else $error("host signal without option");
  hold_grant_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (second_hit && opt_hold) |=> !o_bus_grant_out_n) // see [R14]
    else $error("grant out not pulled low");
  poll_bit_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_cru.rd && selected && func_aux && low_index == omw_pkg::POLL_INDEX && second_seen_q)
      |=> !o_cru_rdata) // see [R15]
    else $error("poll bit not zero after second timeout");
  // Other constant-data positions read straight through
  const_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R05]
    (selected && i_cru.rd && func_aux && low_index != 3'h0) |=> o_cru_rdata == $past(const_bits[low_index]))
    else $error("constant data bit not returned");
  // A read for another module or a port must not disturb the read bit
  unselected_quiet_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R01]
    !(selected && i_cru.rd && func_aux) |=> $stable(o_cru_rdata))
    else $error("read bit changed without a selected read");
  // Counter steps down by one while a period runs
  count_down_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R16]
    (state_q != omw_pkg::OMW_DONE && !count_end && !restart) |=> count_q == CNT_W'($past(count_q) - 1'b1))
    else $error("watchdog counter did not step down");
  // End of the second period lands in the done state
  second_to_done_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R08]
    second_hit |=> state_q == omw_pkg::OMW_DONE)
    else $error("second timeout not reached");
  // Done stays put until software or the bus restarts the watchdog
  done_stays_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R16]
    (state_q == omw_pkg::OMW_DONE && !restart) |=> state_q == omw_pkg::OMW_DONE)
    else $error("done state left without restart");
  // Only the three defined state codes may ever appear
  state_legal_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state_q inside {omw_pkg::OMW_FIRST, omw_pkg::OMW_SECOND, omw_pkg::OMW_DONE})
    else $error("illegal watchdog state code");
  // Second-timeout flag is sticky until restart
  second_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R16]
    (second_seen_q && !restart) |=> second_seen_q)
    else $error("second timeout flag dropped");
  // Restart wipes both timeout latches
  restart_clears_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R07]
    restart |=> (!first_seen_q && !second_seen_q))
    else $error("timeout latches kept over restart");
  // No output opening before the first timeout
  outputs_keep_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R10]
    (!first_seen_q && !first_hit) |=> !o_outputs_open)
    else $error("outputs opened before timeout");
  // No power-fail before the first timeout
  pf_quiet_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R11]
    (!first_seen_q && !first_hit) |=> o_power_fail_n)
    else $error("power fail before timeout");
  // No non-maskable interrupt before the first timeout
  nmi_quiet_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R12]
    (!first_seen_q && !first_hit) |=> o_nmi_n)
    else $error("nmi before timeout");
  // No hold request before the second timeout
  grant_quiet_a: assert property (@(posedge i_clock) disable iff (!i_rst_n) // see [R14]
    (!second_seen_q && !second_hit) |=> o_bus_grant_out_n)
    else $error("grant out low before second timeout");
  // Every access sees exactly one wait cycle
  avs_one_wait_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (req && o_avs_waitrequest) |=> !(req && o_avs_waitrequest))
    else $error("more than one wait cycle");
  // An event always lands in status, even against a clear
  status_set_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (|events) |=> ((status_q & $past(events)) == $past(events)))
    else $error("event lost from status");
  // Any unmasked status bit raises the interrupt
  irq_level_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (|(status_q & mask_q)) |-> o_irq)
    else $error("interrupt not raised");
endmodule : omw_watchdog
`default_nettype wire

// ===== verif/omw_host_model.sv
// Host processor model on the backplane: bit-serial bus strobes and bus I/O reset.
// Assumes callers run in the i_clock domain; signals change only after rising edges.
`timescale 1ns/1ps
`default_nettype none
module omw_host_model (
  input wire logic i_clock,
  output var omw_pkg::omw_cru_s o_cru,
  output logic o_bus_io_reset_n
);
  // Idle bus at time zero
  initial begin
    o_cru = '0;
    o_bus_io_reset_n = 1'b1;
  end
  // Address only, no strobe, so the select compare can be watched
  task automatic place(input logic [11:0] a);
    @(posedge i_clock);
    o_cru <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: 1'b0};
  endtask : place
  // One-cycle strobe; afterwards the address is inverted, not held, as the real bus floats
  task automatic access(input logic [11:0] a, input logic wr);
    @(posedge i_clock);
    o_cru <= '{addr: a, wr: wr, rd: !wr, wdata: 1'b1};
    @(posedge i_clock);
    o_cru <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 1'b0};
  endtask : access
  // Level of the bus I/O reset line
  task automatic io_reset(input logic v);
    @(posedge i_clock);
    o_bus_io_reset_n <= v;
  endtask : io_reset
endmodule : omw_host_model
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the module select and watchdog block.
// Assumes watchdog periods shortened to 20 and 10 cycles; the host model drives the bus.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int F = 20;
  localparam int S = 10;
  logic clk, rst_n, rdata, sel, outs_open, pf_n, nmi_n, grant_n, av_rd, av_wr, av_wait, irq;
  logic bus_rst_n;
  logic [7:0] base, cdata, av_addr;
  logic [31:0] av_wd, av_q, rd_q;
  logic [11:0] a;
  omw_pkg::omw_cru_s bit_serial_io_bus;
  int fails, n_tests, seed, cycles;
  int cfgs[$] = '{0, 1, 2, 4, 6, 8, 15};

  omw_host_model host (.i_clock(clk), .o_cru(bit_serial_io_bus), .o_bus_io_reset_n(bus_rst_n));
  omw_watchdog #(.FIRST_CYC(F), .SECOND_CYC(S)) i_dut (
    .i_clock(clk), .i_rst_n(rst_n), .i_bus_io_reset_n(bus_rst_n), .i_cru(bit_serial_io_bus),
    .o_cru_rdata(rdata), .o_cru_selected(sel), .i_base_select_jumpers(base),
    .i_constant_data_jumpers(cdata), .o_outputs_open(outs_open), .o_power_fail_n(pf_n),
    .o_nmi_n(nmi_n), .o_bus_grant_out_n(grant_n), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
    .o_avs_readdata(av_q), .o_avs_waitrequest(av_wait), .o_irq(irq));

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Avalon access: hold until waitrequest is sampled low, take read data at that edge
  task automatic av(input logic [7:0] ad, input logic w, input logic [31:0] d);
    @(posedge clk);
    av_addr <= ad;
    av_wr <= w;
    av_rd <= !w;
    av_wd <= d;
    do begin
      @(posedge clk);
    end while (av_wait !== 1'b0);
    rd_q = av_q;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask : av
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Expected actions from the model: ph 0 running, 1 after first, 2 after second
  task automatic outs(input int c, input int ph);
    chk("outputs_open", outs_open, ph > 0 && c[0]);
    chk("power_fail_n", pf_n, !(ph > 0 && c[1] && !c[2]));
    chk("nmi_n", nmi_n, !(ph > 0 && c[2]));
    chk("grant_out_n", grant_n, !(ph > 1 && c[3]));
  endtask : outs
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    seed = 44718;
    rst_n = 1'b0;
    av_addr = '0;
    av_rd = 1'b0;
    av_wr = 1'b0;
    av_wd = '0;
    base = $random(seed);
    cdata = $random(seed);
    cyc(2);
    rst_n <= 1'b1;
    host.io_reset(1'b0);
    // Select compare over random addresses, half of them on the base
    for (int i = 0; i < 8; i++) begin
      a = $random(seed);
      if (i[0]) a[11:4] = base;
      host.place(a);
      #1 chk("selected", sel, a[11:4] == base);
    end
    $display("test select done");
    // Constant data, all eight positions, watchdog held by bus reset
    for (int i = 0; i < 8; i++) begin
      host.access({base, 1'b1, 3'(i)}, 1'b0);
      cyc(1);
      chk("const_bit", rdata, cdata[i]);
    end
    av(omw_pkg::REG_STATE, 1'b0, '0);
    chk("state_held", rd_q, 32'h0);
    av(omw_pkg::REG_CONFIG, 1'b0, '0);
    chk("config_reset", rd_q, 32'(omw_pkg::CFG_RESET));
    av(8'h10, 1'b1, 32'hffffffff);
    av(8'h10, 1'b0, '0);
    chk("unmapped", rd_q, 32'h0);
    $display("test const and regs done");
    host.io_reset(1'b1);
    // Seven option settings from cfgs, each followed by a full timeout sequence
    foreach (cfgs[k]) begin
      av(omw_pkg::REG_CONFIG, 1'b1, cfgs[k]);
      av(omw_pkg::REG_MASK, 1'b1, 32'(k % 4));
      av(omw_pkg::REG_STATUS, 1'b1, 32'h7);
      // The clear lands at the edge the write ends on, so look once it has settled
      #1 chk("irq_clear", irq, 1'b0);
      host.access({base, 1'b1, 1'b0, 2'($random(seed))}, 1'b1);
      cyc(F - 4);
      outs(cfgs[k], 0);
      cyc(8);
      outs(cfgs[k], 1);
      cyc(S);
      outs(cfgs[k], 2);
      host.access({base, 4'h8}, 1'b0);
      cyc(1);
      chk("poll_bit", rdata, 1'b0);
      av(omw_pkg::REG_STATE, 1'b0, '0);
      chk("state_done", rd_q, 32'he);
      av(omw_pkg::REG_STATUS, 1'b0, '0);
      chk("status", rd_q, 32'h7);
      chk("irq", irq, (k % 4) != 0);
      $display("test watchdog cfg %0d done", cfgs[k]);
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
